// ### inc/pmbus_op_params.svh
// Constants of the conversion-control command link and the host's register map
`ifndef PMBUS_OP_PARAMS_SVH
`define PMBUS_OP_PARAMS_SVH

// Command codes
`define CMD_CONV_CTRL 8'h01
`define CMD_CLEAR_STATUS 8'h03
`define CMD_BLOCK_SCRATCH 8'hb0

// Conversion-control byte layout and reset value
`define OP_RESET 8'h00
`define OP_ON_BIT 7
`define OP_SOFT_BIT 6
`define OP_MARGIN_MSB 5
`define OP_MARGIN_LSB 2

// Margin codes
`define MARGIN_OFF0 4'h0
`define MARGIN_OFF1 4'h1
`define MARGIN_OFF2 4'h2
`define MARGIN_LOW_IGN 4'h5
`define MARGIN_LOW_ACT 4'h6
`define MARGIN_HIGH_IGN 4'h9
`define MARGIN_HIGH_ACT 4'ha

// Block command
`define BLOCK_BYTES 3'd6
`define BLOCK_RESET 48'h000000000000

// Turn-off timing, least times rounded up to whole cycles
`define CLK_PERIOD_NS 4
`define TURNOFF_DELAY_NS 1000
`define TURNOFF_FALL_NS 2000
`define TURNOFF_DELAY_CYC ((`TURNOFF_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TURNOFF_FALL_CYC ((`TURNOFF_FALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Host APB register offsets
`define REG_CTRL 8'h00
`define REG_WDATA_LO 8'h04
`define REG_WDATA_HI 8'h08
`define REG_RDATA_LO 8'h0c
`define REG_RDATA_HI 8'h10
`define REG_STATUS 8'h14

// Host control fields
`define CTRL_CODE_LSB 0
`define CTRL_READ_BIT 8
`define CTRL_COUNT_LSB 9
`define CTRL_GO_BIT 31
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_NACK_BIT 2
`define STAT_ALERT_BIT 3

`endif

// ### inc/pmbus_op_pkg.sv
// Types and helpers shared by both ends of the command link
`default_nettype none
`include "pmbus_op_params.svh"
package pmbus_op_pkg;
    typedef enum logic [1:0] {CONV_OFF, CONV_RUN, CONV_DELAY, CONV_RAMP} conv_state_type;
    typedef enum logic [1:0] {HOST_IDLE, HOST_SEND, HOST_WAIT} host_state_type;
    typedef logic [47:0] block_type;

    // Byte idx lands at bits 8*idx+7 : 8*idx; callers keep idx below 6
    function automatic block_type placeByte(block_type val, logic [2:0] idx, logic [7:0] b);
        block_type r;
        r = val;
        r[{idx, 3'b000} +: 8] = b;
        return r;
    endfunction

    function automatic logic marginLegal(logic [3:0] code);
        return code inside {`MARGIN_OFF0, `MARGIN_OFF1, `MARGIN_OFF2, `MARGIN_LOW_IGN,
                            `MARGIN_LOW_ACT, `MARGIN_HIGH_IGN, `MARGIN_HIGH_ACT};
    endfunction
endpackage
`default_nettype wire

// ### inc/pmbus_op_if.sv
// Byte-wide command link between the bus controller and the converter slave
`timescale 1ns/100ps
`default_nettype none
interface pmbus_op_if;
    logic hostValid;
    logic hostStart;
    logic hostStop;
    logic hostRead;
    logic [7:0] hostByte;
    logic devValid;
    logic devLast;
    logic devNack;
    logic devAlert;
    logic [7:0] devByte;

    modport device(
        input hostValid, hostStart, hostStop, hostRead, hostByte,
        output devValid, devLast, devNack, devAlert, devByte
    );
    modport host(
        output hostValid, hostStart, hostStop, hostRead, hostByte,
        input devValid, devLast, devNack, devAlert, devByte
    );
endinterface
`default_nettype wire

// ### rtl/pmbus_op_device.sv
// Converter end: command slave, conversion-control byte, margin and turn-off sequencing
`timescale 1ns/100ps
`default_nettype none
`include "pmbus_op_params.svh"
module pmbus_op_device
    import pmbus_op_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Command link
    pmbus_op_if.device link,
    // On/off configuration and enable pin
    input wire logic cfgUseControls,
    input wire logic cfgCmdRequired,
    input wire logic cfgPinRequired,
    input wire logic cfgPinActiveHigh,
    input wire logic enablePin,
    // Power stage and voltage target controls
    output logic convActive,
    output logic stageHighZ,
    output logic rampingDown,
    output logic marginLow,
    output logic marginHigh,
    output logic faultsIgnored,
    // Status
    output logic invalidData
);
    logic [7:0] opReg;
    block_type blockReg;
    block_type bufReg;
    logic [7:0] cmdReg;
    logic [2:0] cntReg;
    logic inFrameReg;
    logic rdReg;
    block_type replyReg;
    logic [2:0] replyLeftReg;
    logic devValidReg;
    logic devLastReg;
    logic devNackReg;
    logic [7:0] devByteReg;
    logic cmlReg;
    conv_state_type stateReg;
    conv_state_type stateNext;
    logic [9:0] timerReg;
    logic [9:0] timerNext;
    logic convActiveReg;
    logic stageHighZReg;
    logic rampingDownReg;
    logic marginLowReg;
    logic marginHighReg;
    logic faultsIgnoredReg;

    // Frame decode
    wire logic frameEnd = link.hostValid & link.hostStop;
    wire logic isData = link.hostValid & ~link.hostStart & inFrameReg;
    wire logic [7:0] frameCode = link.hostStart ? link.hostByte : cmdReg;
    wire logic frameRead = link.hostStart ? link.hostRead : rdReg;
    // Count saturates so an overlong frame never matches a legal length
    wire logic [2:0] cntInc = (cntReg == 3'd7) ? cntReg : cntReg + 3'd1;
    wire logic [2:0] dataCount = link.hostStart ? 3'd0 : (isData ? cntInc : cntReg);
    wire logic storeByte = isData && (cntReg < `BLOCK_BYTES);
    wire block_type frameData = storeByte ? placeByte(bufReg, cntReg, link.hostByte) : bufReg;

    // Write acceptance
    wire logic endWrite = frameEnd & ~frameRead;
    wire logic endRead = frameEnd & link.hostStart & link.hostRead;
    wire logic opWrite = endWrite && (frameCode == `CMD_CONV_CTRL) && (dataCount == 3'd1);
    wire logic opLegal = marginLegal(frameData[`OP_MARGIN_MSB:`OP_MARGIN_LSB]);
    wire logic opAccept = opWrite & opLegal;
    wire logic blkAccept = endWrite && (frameCode == `CMD_BLOCK_SCRATCH) && (dataCount == `BLOCK_BYTES);
    wire logic clrAccept = endWrite && (frameCode == `CMD_CLEAR_STATUS) && (dataCount == 3'd0);
    wire logic wrReject = endWrite & ~opAccept & ~blkAccept & ~clrAccept;

    // Read source
    wire logic rdOp = (link.hostByte == `CMD_CONV_CTRL);
    wire logic rdBlk = (link.hostByte == `CMD_BLOCK_SCRATCH);
    wire logic [2:0] readLen = rdOp ? 3'd1 : (rdBlk ? `BLOCK_BYTES : 3'd0);
    wire block_type readValue = rdOp ? {40'h0000000000, opReg} : blockReg;
    wire logic rdReject = endRead & (readLen == 3'd0);

    // Conversion request
    wire logic pinOn = (enablePin == cfgPinActiveHigh);
    wire logic cmdOn = opReg[`OP_ON_BIT];
    wire logic runReq = ~cfgUseControls | ((~cfgCmdRequired | cmdOn) & (~cfgPinRequired | pinOn));
    wire logic softOff = opReg[`OP_SOFT_BIT];

    // Margin decode of the stored byte
    wire logic [3:0] marginCode = opReg[`OP_MARGIN_MSB:`OP_MARGIN_LSB];
    wire logic mLow = (marginCode == `MARGIN_LOW_IGN) | (marginCode == `MARGIN_LOW_ACT);
    wire logic mHigh = (marginCode == `MARGIN_HIGH_IGN) | (marginCode == `MARGIN_HIGH_ACT);
    wire logic mIgnore = ((marginCode == `MARGIN_LOW_IGN) | (marginCode == `MARGIN_HIGH_IGN)) & cmdOn;

    // Frame tracking
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            inFrameReg <= 1'b0;
            cmdReg <= 8'h00;
            cntReg <= 3'd0;
            rdReg <= 1'b0;
            bufReg <= `BLOCK_RESET;
        end else if (link.hostValid) begin
            inFrameReg <= ~link.hostStop;
            cmdReg <= frameCode;
            cntReg <= dataCount;
            rdReg <= frameRead;
            bufReg <= link.hostStart ? `BLOCK_RESET : frameData;
        end
    end

    // Command registers; bits 1:0 of the control byte always read zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            opReg <= `OP_RESET;
            blockReg <= `BLOCK_RESET;
        end else begin
            if (opAccept) begin
                opReg <= {frameData[7:2], 2'b00};
            end
            if (blkAccept) begin
                blockReg <= frameData;
            end
        end
    end

    // Sticky invalid-data flag; a new reject wins over a clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmlReg <= 1'b0;
        end else begin
            cmlReg <= (cmlReg & ~clrAccept) | wrReject | rdReject;
        end
    end

    // Answers: read bytes go out one per cycle, lowest first
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            replyReg <= `BLOCK_RESET;
            replyLeftReg <= 3'd0;
            devValidReg <= 1'b0;
            devLastReg <= 1'b0;
            devNackReg <= 1'b0;
            devByteReg <= 8'h00;
        end else if (endRead) begin
            devValidReg <= 1'b1;
            devByteReg <= (readLen == 3'd0) ? 8'h00 : readValue[7:0];
            devLastReg <= (readLen <= 3'd1);
            devNackReg <= rdReject;
            replyReg <= readValue >> 8;
            replyLeftReg <= (readLen == 3'd0) ? 3'd0 : readLen - 3'd1;
        end else if (endWrite) begin
            devValidReg <= 1'b1;
            devByteReg <= 8'h00;
            devLastReg <= 1'b1;
            devNackReg <= wrReject;
        end else if (replyLeftReg != 3'd0) begin
            devValidReg <= 1'b1;
            devByteReg <= replyReg[7:0];
            devLastReg <= (replyLeftReg == 3'd1);
            devNackReg <= 1'b0;
            replyReg <= replyReg >> 8;
            replyLeftReg <= replyLeftReg - 3'd1;
        end else begin
            devValidReg <= 1'b0;
            devLastReg <= 1'b0;
            devNackReg <= 1'b0;
        end
    end

    // Turn-off sequencing
    always_comb begin
        stateNext = stateReg;
        timerNext = timerReg;
        unique case (stateReg)
            CONV_OFF: begin
                if (runReq) begin
                    stateNext = CONV_RUN;
                end
            end
            CONV_RUN: begin
                if (!runReq) begin
                    if (softOff) begin
                        stateNext = CONV_DELAY;
                        timerNext = 10'(`TURNOFF_DELAY_CYC - 1);
                    end else begin
                        stateNext = CONV_OFF;
                    end
                end
            end
            CONV_DELAY: begin
                if (runReq) begin
                    stateNext = CONV_RUN;
                end else if (timerReg == 10'd0) begin
                    stateNext = CONV_RAMP;
                    timerNext = 10'(`TURNOFF_FALL_CYC - 1);
                end else begin
                    timerNext = timerReg - 10'd1;
                end
            end
            CONV_RAMP: begin
                // A restart request waits until the ramp reaches zero
                if (timerReg == 10'd0) begin
                    stateNext = CONV_OFF;
                end else begin
                    timerNext = timerReg - 10'd1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stateReg <= CONV_OFF;
            timerReg <= 10'd0;
        end else begin
            stateReg <= stateNext;
            timerReg <= timerNext;
        end
    end

    // Registered controls toward the power stage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            convActiveReg <= 1'b0;
            stageHighZReg <= 1'b1;
            rampingDownReg <= 1'b0;
            marginLowReg <= 1'b0;
            marginHighReg <= 1'b0;
            faultsIgnoredReg <= 1'b0;
        end else begin
            convActiveReg <= (stateNext == CONV_RUN) | (stateNext == CONV_DELAY);
            stageHighZReg <= (stateNext == CONV_OFF);
            rampingDownReg <= (stateNext == CONV_RAMP);
            marginLowReg <= mLow;
            marginHighReg <= mHigh;
            faultsIgnoredReg <= mIgnore;
        end
    end

    assign convActive = convActiveReg;
    assign stageHighZ = stageHighZReg;
    assign rampingDown = rampingDownReg;
    assign marginLow = marginLowReg;
    assign marginHigh = marginHighReg;
    assign faultsIgnored = faultsIgnoredReg;
    assign invalidData = cmlReg;
    assign link.devValid = devValidReg;
    assign link.devLast = devLastReg;
    assign link.devNack = devNackReg;
    assign link.devByte = devByteReg;
    assign link.devAlert = cmlReg;
endmodule
`default_nettype wire

// ### rtl/pmbus_op_host.sv
// Bus controller end: APB registers drive byte and block transactions on the link
`timescale 1ns/100ps
`default_nettype none
`include "pmbus_op_params.svh"
module pmbus_op_host
    import pmbus_op_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Command link
    pmbus_op_if.host link
);
    host_state_type stateReg;
    logic [7:0] codeReg;
    logic readReg;
    logic [2:0] countReg;
    block_type wdataReg;
    block_type rdataReg;
    logic [2:0] idxReg;
    logic [2:0] rdIdxReg;
    logic doneReg;
    logic nackReg;
    logic [31:0] prdataReg;
    logic preadyReg;
    logic pslverrReg;
    logic hostValidReg;
    logic hostStartReg;
    logic hostStopReg;
    logic hostReadReg;
    logic [7:0] hostByteReg;
    logic [31:0] readMux;

    wire logic busy = (stateReg != HOST_IDLE);
    wire logic setup = psel & ~penable;
    wire logic wrTake = psel & penable & preadyReg & pwrite;
    wire logic addrHit = paddr inside {`REG_CTRL, `REG_WDATA_LO, `REG_WDATA_HI,
                                       `REG_RDATA_LO, `REG_RDATA_HI, `REG_STATUS};
    // Control and write data are frozen while a transaction runs
    wire logic ctrlWr = wrTake && (paddr == `REG_CTRL) && !busy;
    wire logic go = ctrlWr & pwdata[`CTRL_GO_BIT];
    wire logic [2:0] goCount = pwdata[`CTRL_COUNT_LSB +: 3];
    wire logic goStop = pwdata[`CTRL_READ_BIT] | (goCount == 3'd0);
    wire logic [2:0] sendIdx = idxReg - 3'd1;
    wire logic [7:0] sendByte = wdataReg[{sendIdx, 3'b000} +: 8];
    wire logic doneClr = wrTake && (paddr == `REG_STATUS) && pwdata[`STAT_DONE_BIT];
    wire logic replyEnd = (stateReg == HOST_WAIT) & link.devValid & link.devLast;
    wire logic rdStore = (stateReg == HOST_WAIT) && link.devValid && (rdIdxReg < `BLOCK_BYTES);

    always_comb begin
        readMux = 32'h00000000;
        unique case (paddr)
            `REG_CTRL: readMux = {20'h00000, countReg, readReg, codeReg};
            `REG_WDATA_LO: readMux = wdataReg[31:0];
            `REG_WDATA_HI: readMux = {16'h0000, wdataReg[47:32]};
            `REG_RDATA_LO: readMux = rdataReg[31:0];
            `REG_RDATA_HI: readMux = {16'h0000, rdataReg[47:32]};
            `REG_STATUS: readMux = {28'h0000000, link.devAlert, nackReg, doneReg, busy};
            default: readMux = 32'h00000000;
        endcase
    end

    // One-cycle access phase: the answer is prepared during setup
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdataReg <= 32'h00000000;
            preadyReg <= 1'b0;
            pslverrReg <= 1'b0;
        end else begin
            prdataReg <= setup ? readMux : prdataReg;
            preadyReg <= setup;
            pslverrReg <= setup & ~addrHit;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            codeReg <= 8'h00;
            readReg <= 1'b0;
            countReg <= 3'd0;
            wdataReg <= `BLOCK_RESET;
        end else if (ctrlWr) begin
            codeReg <= pwdata[`CTRL_CODE_LSB +: 8];
            readReg <= pwdata[`CTRL_READ_BIT];
            countReg <= goCount;
        end else if (wrTake && !busy && paddr == `REG_WDATA_LO) begin
            wdataReg[31:0] <= pwdata;
        end else if (wrTake && !busy && paddr == `REG_WDATA_HI) begin
            wdataReg[47:32] <= pwdata[15:0];
        end
    end

    // Transaction sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stateReg <= HOST_IDLE;
            idxReg <= 3'd0;
            hostValidReg <= 1'b0;
            hostStartReg <= 1'b0;
            hostStopReg <= 1'b0;
            hostReadReg <= 1'b0;
            hostByteReg <= 8'h00;
        end else if (go) begin
            stateReg <= goStop ? HOST_WAIT : HOST_SEND;
            idxReg <= 3'd1;
            hostValidReg <= 1'b1;
            hostStartReg <= 1'b1;
            hostStopReg <= goStop;
            hostReadReg <= pwdata[`CTRL_READ_BIT];
            hostByteReg <= pwdata[`CTRL_CODE_LSB +: 8];
        end else if (stateReg == HOST_SEND) begin
            stateReg <= (idxReg == countReg) ? HOST_WAIT : HOST_SEND;
            idxReg <= idxReg + 3'd1;
            hostValidReg <= 1'b1;
            hostStartReg <= 1'b0;
            hostStopReg <= (idxReg == countReg);
            hostByteReg <= sendByte;
        end else begin
            stateReg <= replyEnd ? HOST_IDLE : stateReg;
            hostValidReg <= 1'b0;
            hostStartReg <= 1'b0;
            hostStopReg <= 1'b0;
        end
    end

    // Reply collection; done is sticky and a new completion wins over its clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdataReg <= `BLOCK_RESET;
            rdIdxReg <= 3'd0;
            doneReg <= 1'b0;
            nackReg <= 1'b0;
        end else begin
            if (go) begin
                rdataReg <= `BLOCK_RESET;
                rdIdxReg <= 3'd0;
            end else if (rdStore) begin
                rdataReg <= placeByte(rdataReg, rdIdxReg, link.devByte);
                rdIdxReg <= rdIdxReg + 3'd1;
            end
            doneReg <= replyEnd | (doneReg & ~doneClr);
            nackReg <= replyEnd ? link.devNack : nackReg;
        end
    end

    assign prdata = prdataReg;
    assign pready = preadyReg;
    assign pslverr = pslverrReg;
    assign link.hostValid = hostValidReg;
    assign link.hostStart = hostStartReg;
    assign link.hostStop = hostStopReg;
    assign link.hostRead = hostReadReg;
    assign link.hostByte = hostByteReg;
endmodule
`default_nettype wire

// ### tb/pmbus_op_properties.sv
// Link protocol properties between the bus controller and the converter end
`timescale 1ns/100ps
`default_nettype none
`include "pmbus_op_params.svh"
module pmbus_op_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Host to device
    input wire logic hostValid,
    input wire logic hostStart,
    input wire logic hostStop,
    input wire logic hostRead,
    input wire logic [7:0] hostByte,
    // Device to host
    input wire logic devValid,
    input wire logic devLast,
    input wire logic devNack,
    input wire logic devAlert,
    input wire logic [7:0] devByte
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic startRd = hostValid && hostStart && hostStop && hostRead;
    wire logic ctrlWr = hostValid && hostStart && !hostRead && hostByte == `CMD_CONV_CTRL;
    wire logic stopOk = hostValid && hostStop && hostByte[5:2] inside {4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha};
    wire logic stopBad = hostValid && hostStop && !(hostByte[5:2] inside {4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha});

    chk_write_answer: assert property (hostValid && hostStop && !hostRead |=> devValid && devLast && devByte == 8'h00)
        else $error("write frame not answered one cycle after its stop byte");
    chk_ctrl_framing: assert property (ctrlWr |-> !hostStop ##1 (hostValid && hostStop && !hostStart))
        else $error("control write is not exactly one data byte");
    chk_ctrl_read_one: assert property (startRd && hostByte == `CMD_CONV_CTRL |=> devValid && devLast && !devNack)
        else $error("control read did not return a single byte");
    chk_block_burst: assert property (startRd && hostByte == `CMD_BLOCK_SCRATCH
        |=> (devValid && !devLast)[*5] ##1 (devValid && devLast && !devNack))
        else $error("block read did not return six consecutive bytes");
    chk_margin_accept: assert property (ctrlWr ##1 stopOk |=> devLast && !devNack)
        else $error("listed margin code refused");
    chk_margin_reject: assert property (ctrlWr ##1 stopBad |=> devLast && devNack)
        else $error("unlisted margin code accepted");
    chk_nack_flags: assert property (devNack |-> ##[0:2] devAlert)
        else $error("refused transaction did not raise the alert");
    chk_alert_cause: assert property ($rose(devAlert) |-> devNack || $past(devNack) || $past(devNack, 2))
        else $error("alert rose without a refusal");
    chk_no_overlap: assert property (hostValid && hostStart |-> !devValid)
        else $error("new frame started while the device still answered");
endmodule
`default_nettype wire

// ### tb/pmbus_block_order_operation_cmd_test.sv
// Self-checking bench driving the bus controller over APB against the converter end
`timescale 1ns/100ps
`default_nettype none
`include "pmbus_op_params.svh"
module pmbus_block_order_operation_cmd_test import pmbus_op_pkg::*;;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic lastErr = 1'b0;
    logic cfgUseControls = 1'b1;
    logic cfgCmdRequired = 1'b1;
    logic cfgPinRequired = 1'b0;
    logic cfgPinActiveHigh = 1'b1;
    logic enablePin = 1'b0;
    logic convActive, stageHighZ, rampingDown, marginLow, marginHigh, faultsIgnored, invalidData;
    int errCount = 0;
    int numChecks = 0;
    int cyc = 0;
    int stopCyc = 0;
    logic [7:0] hq[$];
    logic [7:0] dq[$];

    pmbus_op_if link();
    pmbus_op_device pmbus_op_device_i (.ref_clk, .rst, .link(link), .cfgUseControls, .cfgCmdRequired,
        .cfgPinRequired, .cfgPinActiveHigh, .enablePin, .convActive, .stageHighZ, .rampingDown,
        .marginLow, .marginHigh, .faultsIgnored, .invalidData);
    pmbus_op_host pmbus_op_host_i (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .link(link));
    pmbus_op_properties pmbus_op_properties_i (.ref_clk, .rst, .hostValid(link.hostValid),
        .hostStart(link.hostStart), .hostStop(link.hostStop), .hostRead(link.hostRead),
        .hostByte(link.hostByte), .devValid(link.devValid), .devLast(link.devLast),
        .devNack(link.devNack), .devAlert(link.devAlert), .devByte(link.devByte));

    always #2 ref_clk = ~ref_clk;

    // Wire monitor: byte order is judged on the link itself
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (link.hostValid && link.hostStop) stopCyc <= cyc;
        if (link.hostValid && !link.hostStart) hq.push_back(link.hostByte);
        if (link.devValid) dq.push_back(link.devByte);
    end

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic endSim;
        if (errCount == 0 && numChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            check("pready", 0, 1);
            endSim();
        end
        r = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic linkCmd(input logic [7:0] code, input logic rd, input logic [2:0] cnt,
                           input logic [47:0] wd, output logic [31:0] st);
        logic [31:0] r;
        int n;
        apb(1'b1, `REG_WDATA_LO, wd[31:0], r);
        apb(1'b1, `REG_WDATA_HI, {16'h0000, wd[47:32]}, r);
        apb(1'b1, `REG_CTRL, {1'b1, 19'h0, cnt, rd, code}, r);
        n = 0;
        do begin
            apb(1'b0, `REG_STATUS, 32'h0, st);
            n++;
        end while (st[`STAT_DONE_BIT] !== 1'b1 && n < 40);
        if (st[`STAT_DONE_BIT] !== 1'b1) begin
            check("done", 0, 1);
            endSim();
        end
        apb(1'b1, `REG_STATUS, 32'h2, r);
    endtask

    task automatic wrOp(input logic [7:0] b, output logic [31:0] st);
        linkCmd(`CMD_CONV_CTRL, 1'b0, 3'd1, {40'h0, b}, st);
    endtask

    task automatic rdOp(output logic [31:0] r);
        logic [31:0] st;
        linkCmd(`CMD_CONV_CTRL, 1'b1, 3'd1, 48'h0, st);
        apb(1'b0, `REG_RDATA_LO, 32'h0, r);
    endtask

    task automatic testReset;
        logic [31:0] r;
        check("stageHighZ", stageHighZ, 1);
        check("convActive", convActive, 0);
        apb(1'b0, 8'h18, 32'h0, r);
        check("slvErr", lastErr, 1);
        rdOp(r);
        check("opReset", r[7:0], 8'h00);
    endtask

    task automatic testMargins;
        logic [3:0] codes[7] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha};
        logic [31:0] st, r;
        foreach (codes[i]) begin
            wrOp({2'b10, codes[i], 2'b11}, st);
            check("nack", st[`STAT_NACK_BIT], 0);
            check("marginLow", marginLow, codes[i] inside {4'h5, 4'h6});
            check("marginHigh", marginHigh, codes[i] inside {4'h9, 4'ha});
            check("faultsIgnored", faultsIgnored, codes[i] inside {4'h5, 4'h9});
            check("convOn", convActive, 1);
            rdOp(r);
            check("readback", r[7:0], {2'b10, codes[i], 2'b00});
        end
    endtask

    task automatic testInvalid;
        logic [31:0] st, r;
        wrOp(8'h8c, st);
        check("badNack", st[`STAT_NACK_BIT], 1);
        check("badAlert", st[`STAT_ALERT_BIT], 1);
        check("invalidData", invalidData, 1);
        rdOp(r);
        check("keptValue", r[7:0], 8'ha8);
        linkCmd(8'h02, 1'b1, 3'd1, 48'h0, st);
        check("rdNack", st[`STAT_NACK_BIT], 1);
        linkCmd(`CMD_CLEAR_STATUS, 1'b0, 3'd0, 48'h0, st);
        check("alertCleared", invalidData, 0);
    endtask

    task automatic testBlock;
        logic [31:0] st, lo, hi;
        hq.delete();
        linkCmd(`CMD_BLOCK_SCRATCH, 1'b0, 3'd6, 48'h665544332211, st);
        check("wrCount", hq.size(), 6);
        for (int k = 0; k < 6; k++) check("wrByte", hq[k], 8'h11 * (k + 1));
        dq.delete();
        linkCmd(`CMD_BLOCK_SCRATCH, 1'b1, 3'd6, 48'h0, st);
        apb(1'b0, `REG_RDATA_LO, 32'h0, lo);
        apb(1'b0, `REG_RDATA_HI, 32'h0, hi);
        check("rdBlock", {hi[15:0], lo}, 48'h665544332211);
        for (int k = 0; k < 6; k++) check("rdByte", dq[k], 8'h11 * (k + 1));
    endtask

    task automatic testPin;
        logic [31:0] st;
        cfgPinRequired <= 1'b1;
        wrOp(8'h80, st);
        check("pinLow", convActive, 0);
        enablePin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check("pinHigh", convActive, 1);
        enablePin <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check("hardOff", stageHighZ, 1);
        cfgPinActiveHigh <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check("pinActLow", convActive, 1);
        cfgPinActiveHigh <= 1'b1;
        cfgUseControls <= 1'b0;
        wrOp(8'h00, st);
        check("noControls", convActive, 1);
        cfgUseControls <= 1'b1;
        cfgPinRequired <= 1'b0;
    endtask

    task automatic testSoftOff;
        logic [31:0] st;
        int n, d;
        wrOp(8'hc0, st);
        wrOp(8'h40, st);
        check("delayRun", convActive, 1);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (rampingDown !== 1'b1 && n < 400);
        d = cyc - stopCyc;
        // Slack of four covers the decode pipeline after the stop byte
        check("softDelay", d >= `TURNOFF_DELAY_CYC && d <= `TURNOFF_DELAY_CYC + 4, 1);
        if (rampingDown !== 1'b1) endSim();
        n = 0;
        while (rampingDown === 1'b1 && n < 600) begin
            @(negedge ref_clk);
            n++;
        end
        check("rampLen", n, `TURNOFF_FALL_CYC);
        check("softStopped", stageHighZ, 1);
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        testReset();
        testMargins();
        testInvalid();
        testBlock();
        testPin();
        testSoftOff();
        endSim();
    end
endmodule
`default_nettype wire
